/* File: common/adc_ctrl_map.svh */
// Purpose: register offsets, field positions, reset values and counts of the converter control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   definitions only
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

// register byte offsets
`define OFS_CONTROL_0        12'h000
`define OFS_PIN_REF_CONFIG   12'h004
`define OFS_TIMING_FORMAT    12'h008
`define OFS_RESULT_HIGH      12'h00C
`define OFS_RESULT_LOW       12'h010
`define OFS_IRQ_STATUS       12'h014
`define OFS_IRQ_MASK         12'h018

// control register 0 fields
`define C0_ON_BIT            0
`define C0_GO_BIT            1
`define C0_SEL_LSB           2
`define C0_SEL_MSB           5
// pin/reference config fields
`define C1_ROLE_LSB          0
`define C1_ROLE_MSB          3
`define C1_POS_REF_BIT       4
`define C1_NEG_REF_BIT       5
// timing/format config fields
`define C2_CLK_LSB           0
`define C2_CLK_MSB           2
`define C2_ACQ_LSB           3
`define C2_ACQ_MSB           5
`define C2_JUSTIFY_BIT       7
// interrupt status/mask fields
`define IRQ_DONE_BIT         0

// reset values
`define ROLE_RESET_FUSE_ONE  4'h0
`define ROLE_RESET_FUSE_ZERO 4'h7
`define SEL_RESET            4'h0
`define C2_RESET             8'h00

// channel and pin counts
`define NUM_PINS             13
`define LAST_CHANNEL         4'hC
`define LARGE_ONLY_LO        4'h5
`define LARGE_ONLY_HI        4'h7
`define ROLE_ALL_ANALOG_MAX  4'h2
`define ROLE_ANALOG_LIMIT    5'h0F

// conversion clock divisors, as terminal counts (divisor - 1)
`define DIV2_LAST            6'h01
`define DIV4_LAST            6'h03
`define DIV8_LAST            6'h07
`define DIV16_LAST           6'h0F
`define DIV32_LAST           6'h1F
`define DIV64_LAST           6'h3F

// acquisition lengths in conversion clock periods
`define ACQ_0                5'h00
`define ACQ_2                5'h02
`define ACQ_4                5'h04
`define ACQ_6                5'h06
`define ACQ_8                5'h08
`define ACQ_12               5'h0C
`define ACQ_16               5'h10
`define ACQ_20               5'h14

// successive approximation
`define RESULT_BITS          10
`define SAR_FIRST_TRIAL      10'h200
`define SAR_FIRST_BIT        4'h9
`define RIGHT_PAD            6'h00
`define LEFT_PAD             6'h00

`endif

/* File: common/adc_ctrl_pkg.sv */
// Purpose: types shared by the converter control block and its bench
// Assumes: constants live in adc_ctrl_map.svh
// Notes:   nothing here is imported; users write adc_ctrl_pkg::name
package adc_ctrl_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        st_idle,
        st_acquire,
        st_convert
    } conv_state_t;

    // everything the analog core needs from the control logic
    typedef struct packed {
        logic [3:0]  input_select;    // analog multiplexer code
        logic        input_present;   // low: no pin behind this code, input floats
        logic        neg_ref_select;  // 1: external negative reference pin
        logic        pos_ref_select;  // 1: external positive reference pin
        logic        sampling;        // hold capacitor tracks the input
        logic        converting;      // hold capacitor disconnected, comparing
        logic [9:0]  trial_code;      // comparison level for the current step
    } core_ctrl_t;

endpackage

/* File: src/adc_channel_and_port_control.sv */
// Purpose: control logic of a 10-bit successive-approximation converter behind an APB slave
// Assumes: all inputs synchronous to pclk; the core's comparator settles within one conversion clock period
// Notes:   one clock domain; internal RC clock arrives as a one-cycle enable, the conversion clock enable is made here from it or by dividing pclk
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"

// Functional notes
// - each conversion yields a 10-bit unsigned value split over high and low result registers
// - ten inputs on the small package, thirteen on the large package
// - input select is control 0 bits 5..2; codes 0..12 pick inputs 0..12
// - codes 13..15 pick no input; conversion returns the floating input reading
// - inputs 5, 6 and 7 exist only on the large package
// - control 0 bit 1 reads 1 while converting, 0 when idle, when enabled
// - control 0 bit 0 enables the converter when 1, disables when 0
// - bits 7 and 6 of control 0 and control 1 ignore writes, read zero
// - control 1 bit 5 picks external negative reference (1) or ground (0)
// - control 1 bit 4 picks external positive reference (1) or supply (0)
// - control 1 bits 3..0 set pin roles; from 3 up one more pin digital
// - pin role field resets to 0 with fuse 1, to 7 with fuse 0
// - exactly five converter registers: two result, three control
// - control 2 bit 7 picks right (1) or left (0) justified result
// - control 2 bits 5..3 set acquisition length: 0,2,4,6,8,12,16,20 periods
// - control 2 bits 2..0 pick clock divide 2,8,32,4,16,64 or internal RC
// - completion loads result, clears the busy flag, sets the done interrupt flag
module adc_channel_and_port_control (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     port_analog_default_fuse,
    input  wire logic                     large_package,
    input  wire logic                     rc_osc_tick,
    input  wire logic                     comparator_high,
    output adc_ctrl_pkg::core_ctrl_t      core_ctrl,
    output logic      [`NUM_PINS-1:0]     pin_is_analog,
    output logic                          irq
);

    // register state
    logic                      converter_on_r;
    logic [3:0]                input_select_r;
    logic                      neg_ref_select_r;
    logic                      pos_ref_select_r;
    logic [3:0]                pin_role_config_r;
    logic [7:0]                timing_format_r;
    logic [9:0]                result_r;
    logic                      irq_status_r;
    logic                      irq_mask_r;
    logic                      role_loaded_r;
    logic [31:0]               prdata_r;
    logic                      pslverr_r;

    // sequencer state
    adc_ctrl_pkg::conv_state_t state_r;
    logic [5:0]                div_cnt_r;
    logic [4:0]                acq_cnt_r;
    logic [9:0]                sar_r;
    logic [3:0]                bit_idx_r;
    logic                      done_pulse_r;

    // decoded strobes and fields
    logic                      wr_access;
    logic                      setup_phase;
    logic                      start_req;
    logic                      tad_tick;
    logic [5:0]                div_last;
    logic                      use_rc;
    logic [4:0]                acq_len;
    logic                      busy;
    logic                      justify_right;
    logic [7:0]                result_high_byte;
    logic [7:0]                result_low_byte;
    logic [7:0]                ctrl0_view;
    logic [7:0]                ctrl1_view;
    logic                      addr_hit;
    logic [31:0]               read_mux;

    // apb: writes land on the access edge, read data is latched in setup
    assign setup_phase = psel && !penable;
    assign wr_access   = psel && penable && pwrite;
    assign pready      = psel && penable;
    assign prdata      = prdata_r;
    assign pslverr     = pslverr_r;

    assign busy          = (state_r != adc_ctrl_pkg::st_idle);
    assign justify_right = timing_format_r[`C2_JUSTIFY_BIT];

    // start needs the enable bit as written in the same word
    assign start_req = wr_access && (paddr == `OFS_CONTROL_0) && pwdata[`C0_GO_BIT]
                       && pwdata[`C0_ON_BIT] && !busy;

    // control 0: enable and input select; bits 7..6 are not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_on_r <= 1'b0;
            input_select_r <= `SEL_RESET;
        end else if (wr_access && paddr == `OFS_CONTROL_0) begin
            converter_on_r <= pwdata[`C0_ON_BIT];
            input_select_r <= pwdata[`C0_SEL_MSB:`C0_SEL_LSB];
        end
    end

    // control 1: references and pin roles; role field takes the fuse just after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            neg_ref_select_r  <= 1'b0;
            pos_ref_select_r  <= 1'b0;
            pin_role_config_r <= `ROLE_RESET_FUSE_ONE;
            role_loaded_r     <= 1'b0;
        end else if (!role_loaded_r) begin
            role_loaded_r     <= 1'b1;
            pin_role_config_r <= port_analog_default_fuse ? `ROLE_RESET_FUSE_ONE
                                                          : `ROLE_RESET_FUSE_ZERO;
        end else if (wr_access && paddr == `OFS_PIN_REF_CONFIG) begin
            neg_ref_select_r  <= pwdata[`C1_NEG_REF_BIT];
            pos_ref_select_r  <= pwdata[`C1_POS_REF_BIT];
            pin_role_config_r <= pwdata[`C1_ROLE_MSB:`C1_ROLE_LSB];
        end
    end

    // control 2: bit 6 is not stored and reads zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timing_format_r <= `C2_RESET;
        end else if (wr_access && paddr == `OFS_TIMING_FORMAT) begin
            timing_format_r <= {pwdata[`C2_JUSTIFY_BIT], 1'b0, pwdata[`C2_ACQ_MSB:`C2_CLK_LSB]};
        end
    end

    // interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= 1'b0;
        end else if (wr_access && paddr == `OFS_IRQ_MASK) begin
            irq_mask_r <= pwdata[`IRQ_DONE_BIT];
        end
    end

    // done flag: write one to clear, a completion in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_r <= 1'b0;
        end else if (done_pulse_r) begin
            irq_status_r <= 1'b1;
        end else if (wr_access && paddr == `OFS_IRQ_STATUS && pwdata[`IRQ_DONE_BIT]) begin
            irq_status_r <= 1'b0;
        end
    end

    assign irq = irq_status_r && irq_mask_r;

    // conversion clock source and divide ratio
    always_comb begin
        use_rc   = 1'b0;
        div_last = `DIV2_LAST;
        case (timing_format_r[`C2_CLK_MSB:`C2_CLK_LSB])
            3'h0:    div_last = `DIV2_LAST;
            3'h1:    div_last = `DIV8_LAST;
            3'h2:    div_last = `DIV32_LAST;
            3'h4:    div_last = `DIV4_LAST;
            3'h5:    div_last = `DIV16_LAST;
            3'h6:    div_last = `DIV64_LAST;
            default: use_rc   = 1'b1;
        endcase
    end

    // acquisition length in conversion clock periods
    always_comb begin
        case (timing_format_r[`C2_ACQ_MSB:`C2_ACQ_LSB])
            3'h1:    acq_len = `ACQ_2;
            3'h2:    acq_len = `ACQ_4;
            3'h3:    acq_len = `ACQ_6;
            3'h4:    acq_len = `ACQ_8;
            3'h5:    acq_len = `ACQ_12;
            3'h6:    acq_len = `ACQ_16;
            3'h7:    acq_len = `ACQ_20;
            default: acq_len = `ACQ_0;
        endcase
    end

    // divider restarts on start so the first divided period is always a full one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= 6'h00;
        end else if (start_req || !busy || div_cnt_r >= div_last) begin
            div_cnt_r <= 6'h00;
        end else begin
            div_cnt_r <= div_cnt_r + 6'h01;
        end
    end

    assign tad_tick = busy && (use_rc ? rc_osc_tick : (div_cnt_r >= div_last));

    // sequencer: acquire for the programmed length, then one bit per period, msb first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r      <= adc_ctrl_pkg::st_idle;
            acq_cnt_r    <= 5'h00;
            sar_r        <= 10'h000;
            bit_idx_r    <= 4'h0;
            done_pulse_r <= 1'b0;
        end else begin
            done_pulse_r <= 1'b0;
            if (wr_access && paddr == `OFS_CONTROL_0 && !pwdata[`C0_ON_BIT]) begin
                state_r <= adc_ctrl_pkg::st_idle;   // disabling aborts with no flag; a result due in the same cycle still loads
            end else begin
                case (state_r)
                    adc_ctrl_pkg::st_idle: begin
                        if (start_req) begin
                            acq_cnt_r <= acq_len;
                            sar_r     <= `SAR_FIRST_TRIAL;
                            bit_idx_r <= `SAR_FIRST_BIT;
                            state_r   <= (acq_len == `ACQ_0) ? adc_ctrl_pkg::st_convert
                                                             : adc_ctrl_pkg::st_acquire;
                        end
                    end
                    adc_ctrl_pkg::st_acquire: begin
                        if (tad_tick) begin
                            acq_cnt_r <= acq_cnt_r - 5'h01;
                            if (acq_cnt_r == 5'h01) begin
                                state_r <= adc_ctrl_pkg::st_convert;
                            end
                        end
                    end
                    adc_ctrl_pkg::st_convert: begin
                        if (tad_tick) begin
                            // keep the trial bit only if the input is at or above the trial level
                            sar_r[bit_idx_r] <= comparator_high;
                            if (bit_idx_r == 4'h0) begin
                                state_r      <= adc_ctrl_pkg::st_idle;
                                done_pulse_r <= 1'b1;
                            end else begin
                                sar_r[bit_idx_r - 4'h1] <= 1'b1;
                                bit_idx_r               <= bit_idx_r - 4'h1;
                            end
                        end
                    end
                    default: state_r <= adc_ctrl_pkg::st_idle;
                endcase
            end
        end
    end

    // result latch: last bit decided joins the stored trial bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_r <= 10'h000;
        end else if (state_r == adc_ctrl_pkg::st_convert && tad_tick && bit_idx_r == 4'h0) begin
            result_r <= {sar_r[9:1], comparator_high};
        end
    end

    // justification only changes the read view, the stored result is untouched
    assign result_high_byte = justify_right ? {`RIGHT_PAD, result_r[9:8]} : result_r[9:2];
    assign result_low_byte  = justify_right ? result_r[7:0] : {result_r[1:0], `LEFT_PAD};

    assign ctrl0_view = {2'b00, input_select_r, busy && converter_on_r, converter_on_r};
    assign ctrl1_view = {2'b00, neg_ref_select_r, pos_ref_select_r, pin_role_config_r};

    // read decode: five converter registers plus interrupt status and mask
    always_comb begin
        addr_hit = 1'b1;
        read_mux = 32'h0000_0000;
        case (paddr)
            `OFS_CONTROL_0:      read_mux = {24'h000000, ctrl0_view};
            `OFS_PIN_REF_CONFIG: read_mux = {24'h000000, ctrl1_view};
            `OFS_TIMING_FORMAT:  read_mux = {24'h000000, timing_format_r};
            `OFS_RESULT_HIGH:    read_mux = {24'h000000, result_high_byte};
            `OFS_RESULT_LOW:     read_mux = {24'h000000, result_low_byte};
            `OFS_IRQ_STATUS:     read_mux = {31'h00000000, irq_status_r};
            `OFS_IRQ_MASK:       read_mux = {31'h00000000, irq_mask_r};
            default:             addr_hit = 1'b0;
        endcase
    end

    // read data and error are registered in setup and held through the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup_phase) begin
            prdata_r  <= pwrite ? 32'h0000_0000 : read_mux;
            pslverr_r <= !addr_hit;
        end
    end

    // pin roles: code c >= 3 turns pins 12 down to 15-c digital; small package lacks 5..7
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_PINS; gi++) begin : g_pin
            localparam logic [4:0] PIN_IDX = 5'(gi);
            localparam logic       SMALL_ABSENT = (gi >= 5) && (gi <= 7);
            assign pin_is_analog[gi] = ((pin_role_config_r <= `ROLE_ALL_ANALOG_MAX)
                                        || ((PIN_IDX + {1'b0, pin_role_config_r}) < `ROLE_ANALOG_LIMIT))
                                       && (large_package || !SMALL_ABSENT);
        end
    endgenerate

    // core controls; unimplemented codes, and large-only inputs on small parts, leave the input floating
    assign core_ctrl.input_select   = input_select_r;
    assign core_ctrl.input_present  = (input_select_r <= `LAST_CHANNEL)
                                      && (large_package || input_select_r < `LARGE_ONLY_LO
                                          || input_select_r > `LARGE_ONLY_HI);
    assign core_ctrl.neg_ref_select = neg_ref_select_r;
    assign core_ctrl.pos_ref_select = pos_ref_select_r;
    assign core_ctrl.sampling       = (state_r != adc_ctrl_pkg::st_convert);
    assign core_ctrl.converting     = (state_r == adc_ctrl_pkg::st_convert);
    assign core_ctrl.trial_code     = sar_r;

    // checks
    a_start_needs_on: assert property (@(posedge pclk) disable iff (!presetn)
        !converter_on_r |-> state_r == adc_ctrl_pkg::st_idle)
        else $error("converter busy while disabled");

    a_go_starts: assert property (@(posedge pclk) disable iff (!presetn)
        start_req |=> busy)
        else $error("enabled start did not leave idle");

    a_off_no_start: assert property (@(posedge pclk) disable iff (!presetn)
        (!busy && !start_req) |=> !busy)
        else $error("conversion began without an enabled start");

    a_busy_reads: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl0_view[`C0_GO_BIT] == (busy && converter_on_r))
        else $error("busy flag view wrong");

    sequence s_last_step;
        state_r == adc_ctrl_pkg::st_convert && tad_tick && bit_idx_r == 4'h0;
    endsequence

    sequence s_finish;
        !busy && done_pulse_r ##1 irq_status_r;
    endsequence

    a_done_sequence: assert property (@(posedge pclk) disable iff (!presetn)
        s_last_step and !(wr_access && paddr == `OFS_CONTROL_0 && !pwdata[`C0_ON_BIT]) |=> s_finish)
        else $error("completion did not clear busy and set the flag");

    a_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl0_view[7:6] == 2'b00 && ctrl1_view[7:6] == 2'b00 && timing_format_r[6] == 1'b0)
        else $error("unimplemented bits not zero");

    a_fuse_default: assert property (@(posedge pclk) disable iff (!presetn)
        !role_loaded_r |=> pin_role_config_r == ($past(port_analog_default_fuse) ? `ROLE_RESET_FUSE_ONE
                                                                                  : `ROLE_RESET_FUSE_ZERO))
        else $error("pin role reset value wrong");

    a_pin_roles: assert property (@(posedge pclk) disable iff (!presetn)
        large_package && pin_role_config_r == 4'hF |-> pin_is_analog == 13'h0000)
        else $error("all-digital code left an analog pin");

    a_floating_code: assert property (@(posedge pclk) disable iff (!presetn)
        input_select_r > `LAST_CHANNEL |-> !core_ctrl.input_present)
        else $error("unimplemented code drove an input");

    a_justify_view: assert property (@(posedge pclk) disable iff (!presetn)
        justify_right |-> result_high_byte[7:2] == 6'h00 && result_low_byte == result_r[7:0])
        else $error("right justified view wrong");

endmodule

/* File: tb/adc_core_model.sv */
// Purpose: behavioural analog core and internal RC clock
// Assumes: level is the voltage code on whichever present input is selected
// Notes:   an absent input floats; modelled as a comparator that flips every cycle
`timescale 1ns/1ps
module adc_core_model (
    input  wire adc_ctrl_pkg::core_ctrl_t core_ctrl,
    input  wire logic                     pclk,
    input  wire logic [9:0]               level,
    output logic                          comparator_high,
    output logic                          rc_osc_tick
);
    logic [1:0] rc_cnt_r = 2'h0;
    // free-running RC oscillator, one tick every fourth cycle
    always_ff @(posedge pclk) begin
        rc_cnt_r <= rc_cnt_r + 2'h1;
    end
    assign rc_osc_tick = (rc_cnt_r == 2'h3);
    // no stable answer from a floating input
    assign comparator_high = core_ctrl.input_present ? (level >= core_ctrl.trial_code) : rc_cnt_r[0];
endmodule

/* File: tb/adc_channel_and_port_control_test.sv */
// Purpose: register and conversion tests of the converter control block
// Assumes: large package and fuse at 1, then a second reset into the small package with fuse at 0
// Notes:   a global cycle ceiling ends a hung run
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
module adc_channel_and_port_control_test;
    logic                     pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]              paddr = 12'h000;
    logic [31:0]              pwdata = 32'h0, prdata, rd_q;
    logic                     pready, pslverr, err_q, irq, comparator_high, rc_osc_tick;
    logic [9:0]               level = 10'h2A5;
    logic                     fuse = 1'b1, large_pkg = 1'b1;
    logic [`NUM_PINS-1:0]     pin_is_analog;
    adc_ctrl_pkg::core_ctrl_t core_ctrl;
    int                       n_mismatch = 0, compares = 0, cyc = 0;

    adc_channel_and_port_control adc_channel_and_port_control_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_analog_default_fuse(fuse), .large_package(large_pkg), .rc_osc_tick(rc_osc_tick),
        .comparator_high(comparator_high), .core_ctrl(core_ctrl), .pin_is_analog(pin_is_analog), .irq(irq));
    adc_core_model adc_core_model_i (.core_ctrl(core_ctrl), .pclk(pclk), .level(level),
        .comparator_high(comparator_high), .rc_osc_tick(rc_osc_tick));

    initial begin
        forever #10 pclk = ~pclk;
    end

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_q, exp);
    endtask

    // channel 3 conversion; the ceiling cuts a busy flag that never clears
    task automatic conv(input logic [31:0] cfg, input logic [31:0] hi, input logic [31:0] lo, input logic ie);
        wr(`OFS_TIMING_FORMAT, cfg);
        wr(`OFS_IRQ_MASK, {31'h0, ie});
        wr(`OFS_CONTROL_0, 32'h0F);
        rd(`OFS_CONTROL_0, 32'h0F);
        do apb(1'b0, `OFS_CONTROL_0, 32'h0); while (rd_q[1] !== 1'b0);
        rd(`OFS_CONTROL_0, 32'h0D);
        rd(`OFS_RESULT_HIGH, hi);
        rd(`OFS_RESULT_LOW, lo);
        rd(`OFS_IRQ_STATUS, 32'h1);
        chk({31'h0, irq}, {31'h0, ie});
        wr(`OFS_IRQ_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(`OFS_PIN_REF_CONFIG, 32'h0);
        for (int c = 0; c < 16; c++) begin
            wr(`OFS_PIN_REF_CONFIG, 32'hC0 | 32'(c) | (32'(c & 3) << 4));
            rd(`OFS_PIN_REF_CONFIG, 32'(c) | (32'(c & 3) << 4));
            chk({19'h0, pin_is_analog}, (c < 3) ? 32'h1FFF : 32'h1FFF >> (c - 2));
            chk({30'h0, core_ctrl.neg_ref_select, core_ctrl.pos_ref_select}, 32'(c & 3));
            wr(`OFS_CONTROL_0, 32'hC0 | (32'(c) << 2));
            rd(`OFS_CONTROL_0, 32'(c) << 2);
            chk({28'h0, core_ctrl.input_select}, 32'(c));
            chk({31'h0, core_ctrl.input_present}, {31'h0, c < 13});
        end
        conv(32'h80, 32'h02, 32'hA5, 1'b1);
        conv(32'h3B, 32'hA9, 32'h40, 1'b0);
        conv(32'h8E, 32'h02, 32'hA5, 1'b1);
        conv(32'h14, 32'hA9, 32'h40, 1'b0);
        conv(32'h99, 32'h02, 32'hA5, 1'b1);
        conv(32'h65, 32'hA9, 32'h40, 1'b0);
        rd(`OFS_TIMING_FORMAT, 32'h25);
        conv(32'hAA, 32'h02, 32'hA5, 1'b1);
        conv(32'h37, 32'hA9, 32'h40, 1'b0);
        // clearing the enable bit mid-conversion aborts it
        wr(`OFS_CONTROL_0, 32'h0F);
        wr(`OFS_CONTROL_0, 32'h0C);
        rd(`OFS_CONTROL_0, 32'h0C);
        wr(`OFS_CONTROL_0, 32'h0E);
        rd(`OFS_CONTROL_0, 32'h0C);
        wr(`OFS_CONTROL_0, 32'h0D);
        rd(`OFS_CONTROL_0, 32'h0D);
        rd(`OFS_IRQ_STATUS, 32'h0);
        rd(12'h01C, 32'h0);
        chk({31'h0, err_q}, 32'h1);
        // second reset with the fuse at 0 on the small package
        presetn   <= 1'b0;
        fuse      <= 1'b0;
        large_pkg <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(`OFS_PIN_REF_CONFIG, 32'h07);
        chk({19'h0, pin_is_analog}, 32'h001F);
        wr(`OFS_PIN_REF_CONFIG, 32'h00);
        chk({19'h0, pin_is_analog}, 32'h1F1F);
        wr(`OFS_CONTROL_0, 32'h14);
        chk({31'h0, core_ctrl.input_present}, 32'h0);
        summarize();
    end
endmodule
